// [design/cgts_top.sv]
// Purpose: trim storage, lock tracking and status of the clock generator
// Assumes: control fields arrive from registers on this clock
// Notes: lock detector, oscillator and mode status come from other domains
`timescale 1ns/1ps
module cgts_top
    import cgts_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [CGTS_AW-1:0] i_addr,
    input wire logic [CGTS_DW-1:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic i_background_debug_mode,
    input wire logic [7:0] i_factory_trim,
    input wire logic i_factory_fine,
    input wire logic i_loop_type_select,
    input wire logic i_ref_source_select,
    input wire logic [1:0] i_system_source_select,
    input wire logic i_low_power_select,
    input wire logic i_stop_mode,
    input wire logic i_crystal_request,
    input wire logic i_ext_ref_out_enable,
    input wire logic i_dco_max_narrow,
    input wire logic i_dco_range_select,
    input wire logic i_extra_ref_divide,
    input wire logic [2:0] i_ref_divider,
    input wire logic [3:0] i_vco_multiplier,
    input wire logic i_raw_lock,
    input wire logic i_out_of_tolerance,
    input wire logic i_osc_startup_done,
    input wire logic i_loop_type_ack,
    input wire logic i_ref_source_ack,
    input wire logic [1:0] i_source_mode_ack,
    output logic [CGTS_DW-1:0] o_rd_data,
    output logic [7:0] o_trim_code,
    output logic o_fine_period_bit,
    output logic o_irq,
    output logic o_lock_detect_en,
    output logic o_fll_enable,
    output logic o_pll_enable,
    output logic o_crystal_select,
    output logic o_ext_clock_select
);

    // ************************************************************
    // mode decode helpers
    // ************************************************************

    // mode from source select, reference select, loop select, low power
    function automatic cgts_mode_t mode_of(input logic [1:0] src, input logic ref_source_select,
                                           input logic loop_type_select, input logic lp);
        cgts_mode_t m;
        m = CGTS_FEI;
        case (src)
            CGTS_SRC_LOOP: begin
                if (ref_source_select) m = CGTS_FEI;
                else if (loop_type_select) m = CGTS_PEE;
                else m = CGTS_FEE;
            end
            CGTS_SRC_INT: m = lp ? CGTS_LPI : CGTS_FBI;
            CGTS_SRC_EXT: begin
                if (lp) m = CGTS_LPE;
                else if (loop_type_select) m = CGTS_PBE;
                else m = CGTS_FBE;
            end
            default: m = ref_source_select ? CGTS_FEI : (loop_type_select ? CGTS_PEE : CGTS_FEE);
        endcase
        return m;
    endfunction

    // modes that run from the external reference
    function automatic logic ext_mode(input cgts_mode_t m);
        return (m == CGTS_FEE) || (m == CGTS_FBE) || (m == CGTS_PEE) ||
               (m == CGTS_PBE) || (m == CGTS_LPE);
    endfunction

    // modes that run from the internal reference
    function automatic logic int_mode(input cgts_mode_t m);
        return (m == CGTS_FEI) || (m == CGTS_FBI) || (m == CGTS_LPI);
    endfunction

    // ************************************************************
    // cross-domain inputs
    // ************************************************************
    logic [6:0] async_in;
    logic [6:0] sync_out;
    logic lock_s;
    logic tol_s;
    logic startup_s;
    logic ltype_s;
    logic refsrc_s;
    logic [1:0] mode_s;

    assign async_in = {i_source_mode_ack, i_ref_source_ack, i_loop_type_ack,
                       i_osc_startup_done, i_out_of_tolerance, i_raw_lock};

    cgts_sync #(
        .WIDTH(7)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_async(async_in),
        .o_sync(sync_out)
    );

    assign lock_s = sync_out[0];
    assign tol_s = sync_out[1];
    assign startup_s = sync_out[2];
    assign ltype_s = sync_out[3];
    assign refsrc_s = sync_out[4];
    assign mode_s = sync_out[6:5];

    // ************************************************************
    // state
    // ************************************************************
    logic load_pend_q, load_pend_d;
    logic [7:0] trim_q, trim_d;
    logic fine_q, fine_d;
    logic irq_en_q, irq_en_d;
    logic unlock_q, unlock_d;
    logic locked_once_q, locked_once_d;
    logic hold_q, hold_d;
    logic lock_q, lock_d;
    logic osc_rdy_q, osc_rdy_d;
    logic irq_q, irq_d;
    logic det_en_q, det_en_d;
    logic fll_en_q, fll_en_d;
    logic pll_en_q, pll_en_d;
    logic xtal_q, xtal_d;
    logic ext_clk_q, ext_clk_d;
    logic [CGTS_DW-1:0] rd_q, rd_d;
    cgts_mode_t mode_prev_q;
    logic stop_prev_q;
    logic [13:0] ctl_prev_q;
    logic [7:0] trim_prev_q;

    cgts_mode_t mode_now;
    logic low_pwr_now;
    logic wr_stat;
    logic fll_fed_chg;
    logic pll_fed_chg;
    logic relock_evt;

    // current operating mode
    assign mode_now = mode_of(i_system_source_select, i_ref_source_select,
                              i_loop_type_select, i_low_power_select);
    assign low_pwr_now = (mode_now == CGTS_LPI) || (mode_now == CGTS_LPE) || i_stop_mode;
    assign wr_stat = i_wr_en && (i_addr == CGTS_STAT_OFS);

    // ************************************************************
    // lock-relevant change detection
    // ************************************************************

    // fll side fields; trim counts only in internal fll modes
    always_comb begin
        fll_fed_chg = 1'b0;
        pll_fed_chg = 1'b0;
        if ((mode_now == CGTS_FEE) || (mode_now == CGTS_FBE) ||
            (mode_now == CGTS_FEI) || (mode_now == CGTS_FBI)) begin
            fll_fed_chg = (ctl_prev_q[2:0] != {i_dco_max_narrow, i_dco_range_select,
                                               i_ref_source_select});
        end
        if ((mode_now == CGTS_FEE) || (mode_now == CGTS_FBE)) begin
            fll_fed_chg = fll_fed_chg || (ctl_prev_q[3] != i_extra_ref_divide) ||
                          (ctl_prev_q[6:4] != i_ref_divider);
        end
        if ((mode_now == CGTS_FEI) || (mode_now == CGTS_FBI)) begin
            fll_fed_chg = fll_fed_chg || (trim_prev_q != trim_q);
        end
        if ((mode_now == CGTS_PEE) || (mode_now == CGTS_PBE)) begin
            pll_fed_chg = (ctl_prev_q[6:4] != i_ref_divider) ||
                          (ctl_prev_q[10:7] != i_vco_multiplier);
        end
    end

    // any event that drops lock until the detector sees it again
    assign relock_evt = fll_fed_chg || pll_fed_chg ||
                        (ctl_prev_q[11] != i_loop_type_select) ||
                        (low_pwr_now && !(mode_prev_q == CGTS_LPI ||
                         mode_prev_q == CGTS_LPE || stop_prev_q));

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        load_pend_d = 1'b0;
        trim_d = trim_q;
        fine_d = fine_q;
        irq_en_d = irq_en_q;
        // factory load one cycle after reset release, overrides writes
        if (load_pend_q) begin
            trim_d = i_background_debug_mode ? CGTS_TRIM_DEBUG : i_factory_trim;
            fine_d = i_background_debug_mode ? CGTS_FINE_DEBUG : i_factory_fine;
        end else if (i_wr_en) begin
            // stored values reach here only by software writes
            if (i_addr == CGTS_TRIM_OFS) trim_d = i_wr_data;
            if (i_addr == CGTS_STAT_OFS) fine_d = i_wr_data[CGTS_FINE_BIT];
            if (i_addr == CGTS_CTRL_OFS) irq_en_d = i_wr_data[CGTS_IRQEN_BIT];
        end

        // loops: selection disables the other, low power disables both
        fll_en_d = !i_loop_type_select && !low_pwr_now;
        pll_en_d = i_loop_type_select && !low_pwr_now;
        det_en_d = fll_en_d || pll_en_d;
        xtal_d = i_crystal_request;
        ext_clk_d = !i_crystal_request;

        // hold until detector shows unlock, then relock
        hold_d = hold_q;
        if (relock_evt && (lock_q || hold_q)) hold_d = 1'b1;
        else if (!lock_s) hold_d = 1'b0;
        if (low_pwr_now) hold_d = 1'b1;
        lock_d = det_en_d && lock_s && !hold_d;

        locked_once_d = det_en_q ? (locked_once_q || lock_q) : 1'b0;

        // set wins over a write-one clear
        unlock_d = unlock_q;
        if (wr_stat && i_wr_data[CGTS_UNLOCK_BIT] && unlock_q) unlock_d = 1'b0;
        if (det_en_q && locked_once_q && tol_s) unlock_d = 1'b1;

        irq_d = unlock_d && irq_en_d;

        // oscillator ready tracking
        osc_rdy_d = osc_rdy_q;
        if (!i_crystal_request ||
            (int_mode(mode_now) && !i_ext_ref_out_enable)) begin
            osc_rdy_d = 1'b0;
        end else if ((i_ext_ref_out_enable || ext_mode(mode_now)) && startup_s) begin
            osc_rdy_d = 1'b1;
        end

        // read data valid only in the cycle after the strobe
        rd_d = '0;
        if (i_rd_en) begin
            case (i_addr)
                CGTS_TRIM_OFS: rd_d = trim_q;
                CGTS_STAT_OFS: begin
                    rd_d[CGTS_UNLOCK_BIT] = unlock_q;
                    rd_d[CGTS_LOCK_BIT] = lock_q;
                    rd_d[CGTS_LTYPE_BIT] = ltype_s;
                    rd_d[CGTS_REFSRC_BIT] = refsrc_s;
                    rd_d[CGTS_MODE_HI:CGTS_MODE_LO] = mode_s;
                    rd_d[CGTS_OSCRDY_BIT] = osc_rdy_q;
                    rd_d[CGTS_FINE_BIT] = fine_q;
                end
                CGTS_CTRL_OFS: rd_d[CGTS_IRQEN_BIT] = irq_en_q;
                default: rd_d = '0;
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            load_pend_q <= 1'b1;
            trim_q <= CGTS_TRIM_RST;
            fine_q <= CGTS_FINE_DEBUG;
            irq_en_q <= 1'b0;
            unlock_q <= 1'b0;
            locked_once_q <= 1'b0;
            hold_q <= 1'b0;
            lock_q <= 1'b0;
            osc_rdy_q <= 1'b0;
            irq_q <= 1'b0;
            det_en_q <= 1'b0;
            fll_en_q <= 1'b0;
            pll_en_q <= 1'b0;
            xtal_q <= 1'b0;
            ext_clk_q <= 1'b1;
            rd_q <= '0;
            mode_prev_q <= CGTS_FEI;
            stop_prev_q <= 1'b0;
            ctl_prev_q <= '0;
            trim_prev_q <= CGTS_TRIM_RST;
        end else begin
            load_pend_q <= load_pend_d;
            trim_q <= trim_d;
            fine_q <= fine_d;
            irq_en_q <= irq_en_d;
            unlock_q <= unlock_d;
            locked_once_q <= locked_once_d;
            hold_q <= hold_d;
            lock_q <= lock_d;
            osc_rdy_q <= osc_rdy_d;
            irq_q <= irq_d;
            det_en_q <= det_en_d;
            fll_en_q <= fll_en_d;
            pll_en_q <= pll_en_d;
            xtal_q <= xtal_d;
            ext_clk_q <= ext_clk_d;
            rd_q <= rd_d;
            mode_prev_q <= mode_now;
            stop_prev_q <= i_stop_mode;
            ctl_prev_q <= {2'b00, i_loop_type_select, i_vco_multiplier, i_ref_divider,
                           i_extra_ref_divide, i_dco_max_narrow, i_dco_range_select,
                           i_ref_source_select};
            trim_prev_q <= trim_q;
        end
    end

    // ************************************************************
    // outputs, all from flops
    // ************************************************************
    assign o_rd_data = rd_q;
    assign o_trim_code = trim_q;
    assign o_fine_period_bit = fine_q;
    assign o_irq = irq_q;
    assign o_lock_detect_en = det_en_q;
    assign o_fll_enable = fll_en_q;
    assign o_pll_enable = pll_en_q;
    assign o_crystal_select = xtal_q;
    assign o_ext_clock_select = ext_clk_q; // own flop, so the pin never glitches

endmodule

// [design/cgts_pkg.sv]
// Purpose: shared constants and types for the clock generator trim/status block
// Assumes: 8-bit register port, byte indices as offsets
// Notes: offsets are indices on the plain register port
package cgts_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int CGTS_AW = 2;
    localparam int CGTS_DW = 8;
    localparam logic [CGTS_AW-1:0] CGTS_TRIM_OFS = 2'h0;
    localparam logic [CGTS_AW-1:0] CGTS_STAT_OFS = 2'h1;
    localparam logic [CGTS_AW-1:0] CGTS_CTRL_OFS = 2'h2;

    // ************************************************************
    // status/control field positions
    // ************************************************************
    localparam int CGTS_UNLOCK_BIT = 7;
    localparam int CGTS_LOCK_BIT = 6;
    localparam int CGTS_LTYPE_BIT = 5;
    localparam int CGTS_REFSRC_BIT = 4;
    localparam int CGTS_MODE_HI = 3;
    localparam int CGTS_MODE_LO = 2;
    localparam int CGTS_OSCRDY_BIT = 1;
    localparam int CGTS_FINE_BIT = 0;
    localparam int CGTS_IRQEN_BIT = 7;

    // ************************************************************
    // reset and debug defaults
    // ************************************************************
    localparam logic [7:0] CGTS_TRIM_DEBUG = 8'h80;
    localparam logic CGTS_FINE_DEBUG = 1'h0;
    localparam logic [7:0] CGTS_TRIM_RST = 8'h00;

    // ************************************************************
    // system source select encodings
    // ************************************************************
    localparam logic [1:0] CGTS_SRC_LOOP = 2'h0;
    localparam logic [1:0] CGTS_SRC_INT = 2'h1;
    localparam logic [1:0] CGTS_SRC_EXT = 2'h2;

    // operating modes of the generator
    typedef enum logic [2:0] {
        CGTS_FEI, CGTS_FEE, CGTS_FBI, CGTS_FBE,
        CGTS_PEE, CGTS_PBE, CGTS_LPI, CGTS_LPE
    } cgts_mode_t;

endpackage

// [design/cgts_sync.sv]
// Purpose: two-flop synchroniser for slow level signals
// Assumes: inputs are levels that stay stable for several clocks
// Notes: bits are synchronised independently, no word coherence
`timescale 1ns/1ps
module cgts_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // first stage only feeds second stage
    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;

endmodule

// [test/cgts_monitor.sv]
// Purpose: concurrent checks on the ports of the trim/status block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: the irq enable bit is shadowed here from bus writes
`timescale 1ns/1ps
module cgts_monitor
    import cgts_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [CGTS_AW-1:0] i_addr,
    input wire logic [CGTS_DW-1:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic i_background_debug_mode,
    input wire logic [7:0] i_factory_trim,
    input wire logic i_factory_fine,
    input wire logic i_loop_type_select,
    input wire logic i_crystal_request,
    input wire logic [CGTS_DW-1:0] o_rd_data,
    input wire logic [7:0] o_trim_code,
    input wire logic o_fine_period_bit,
    input wire logic o_irq,
    input wire logic o_lock_detect_en,
    input wire logic o_fll_enable,
    input wire logic o_pll_enable,
    input wire logic o_crystal_select,
    input wire logic o_ext_clock_select
);
    logic en_q;
    logic en_d;

    // ************************************************************
    // shadow of the irq enable
    // ************************************************************
    // next value follows writes to the irq control index
    always_comb begin
        en_d = en_q;
        if (i_wr_en && i_addr == CGTS_CTRL_OFS) begin
            en_d = i_wr_data[CGTS_IRQEN_BIT];
        end
    end

    // registered like the enable register, which irq follows on the same edge
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            en_q <= 1'b0;
        end else begin
            en_q <= en_d;
        end
    end

    // ************************************************************
    // port relations
    // ************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    chk_reset_trim: assert property (!$past(i_reset_n) |=>
        o_trim_code == ($past(i_background_debug_mode) ? CGTS_TRIM_DEBUG : $past(i_factory_trim)))
        else $error("trim after reset wrong");
    chk_reset_fine: assert property (!$past(i_reset_n) |=>
        o_fine_period_bit == (!$past(i_background_debug_mode) && $past(i_factory_fine)))
        else $error("fine bit after reset wrong");
    chk_trim_write: assert property (i_wr_en && i_addr == CGTS_TRIM_OFS |=>
        o_trim_code == $past(i_wr_data)) else $error("trim write lost");
    // hardware never alters trim on its own once loaded
    chk_trim_hold: assert property ($past(i_reset_n) && !(i_wr_en && i_addr == CGTS_TRIM_OFS)
        |=> $stable(o_trim_code)) else $error("trim changed without write");
    chk_fine_write: assert property (i_wr_en && i_addr == CGTS_STAT_OFS |=>
        o_fine_period_bit == $past(i_wr_data[CGTS_FINE_BIT])) else $error("fine write lost");
    // irq and the enable register move on the same edge
    chk_irq_gate: assert property (!en_q |-> !o_irq)
        else $error("irq raised while disabled");
    chk_loop_excl: assert property (o_pll_enable |->
        $past(i_loop_type_select) && !o_fll_enable) else $error("loop enables clash");
    chk_detect_off: assert property (!o_fll_enable && !o_pll_enable |-> !o_lock_detect_en)
        else $error("lock detect on with loops off");
    chk_crystal_sel: assert property ($past(i_reset_n) |->
        o_crystal_select == $past(i_crystal_request) && o_ext_clock_select == !o_crystal_select)
        else $error("crystal select wrong");
    chk_read_trim: assert property (i_rd_en && i_addr == CGTS_TRIM_OFS |=>
        o_rd_data == $past(o_trim_code)) else $error("trim readback wrong");
endmodule

bind cgts_top cgts_monitor u_mon (.*);

// [test/tb_top.sv]
// Purpose: self-checking bench for the trim/status block
// Assumes: control levels share the core clock; status inputs settle in 2 edges
// Notes: bus tasks drive after a rising edge and sample 1 ns after it
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module tb_top;
    import cgts_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_reset_n, i_wr_en, i_rd_en, i_background_debug_mode, i_factory_fine;
    logic i_loop_type_select, i_ref_source_select, i_low_power_select, i_stop_mode;
    logic i_crystal_request, i_ext_ref_out_enable, i_dco_max_narrow, i_dco_range_select;
    logic i_extra_ref_divide, i_raw_lock, i_out_of_tolerance, i_osc_startup_done;
    logic i_loop_type_ack, i_ref_source_ack, o_fine_period_bit, o_irq, o_lock_detect_en;
    logic o_fll_enable, o_pll_enable, o_crystal_select, o_ext_clock_select;
    logic [1:0] i_addr, i_system_source_select, i_source_mode_ack;
    logic [2:0] i_ref_divider;
    logic [3:0] i_vco_multiplier;
    logic [7:0] i_wr_data, i_factory_trim, o_rd_data, o_trim_code;
    logic [7:0] pat [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
    int fail_count = 0;
    int compares = 0;

    cgts_top dut (.*);

    // ************************************************************
    // clock, tasks, watchdog
    // ************************************************************
    always #2 i_core_clk = ~i_core_clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_core_clk);
        i_wr_en <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge i_core_clk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd_en <= 1'b0;
        #1;
        `CHK(o_rd_data & m, e)
    endtask

    task automatic rst(input logic dbg);
        @(posedge i_core_clk);
        i_background_debug_mode <= dbg;
        i_reset_n <= 1'b0;
        cyc(5);
        i_reset_n <= 1'b1;
        cyc(2);
        #1;
    endtask

    task automatic final_report();
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // generous bound, the sequence needs well under a thousand cycles
    initial begin
        cyc(20000);
        fail_count++;
        final_report();
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        {i_reset_n, i_wr_en, i_rd_en, i_background_debug_mode, i_addr, i_wr_data} = '0;
        {i_loop_type_select, i_system_source_select, i_low_power_select, i_stop_mode} = '0;
        {i_crystal_request, i_ext_ref_out_enable, i_dco_max_narrow, i_dco_range_select} = '0;
        {i_extra_ref_divide, i_ref_divider, i_vco_multiplier, i_raw_lock} = '0;
        {i_out_of_tolerance, i_osc_startup_done, i_loop_type_ack, i_ref_source_ack} = '0;
        i_source_mode_ack = 2'h0;
        i_factory_trim = 8'h5A;
        i_factory_fine = 1'b1;
        i_ref_source_select = 1'b1;
        rst(1'b0);
        `CHK(o_trim_code, 8'h5A)
        rd_chk(CGTS_STAT_OFS, 8'h01, 8'h01);
        rst(1'b1);
        `CHK(o_trim_code, CGTS_TRIM_DEBUG)
        `CHK(o_fine_period_bit, CGTS_FINE_DEBUG)
        // boundary codes, written back to back with readback
        foreach (pat[i]) begin
            wr(CGTS_TRIM_OFS, pat[i]);
            `CHK(o_trim_code, pat[i])
            rd_chk(CGTS_TRIM_OFS, pat[i], 8'hFF);
        end
        wr(CGTS_STAT_OFS, 8'h01);
        `CHK(o_fine_period_bit, 1'b1)
        wr(CGTS_STAT_OFS, 8'h00);
        `CHK(o_fine_period_bit, 1'b0)
        wr(2'h3, 8'hFF);
        rd_chk(2'h3, 8'h00, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            i_source_mode_ack <= i[1:0];
            i_loop_type_ack <= i[0];
            i_ref_source_ack <= i[1];
            cyc(4);
            rd_chk(CGTS_STAT_OFS, {2'b00, i[0], i[1], i[1:0], 2'b00}, 8'h3C);
        end
        // oscillator ready: set, cleared in internal mode, set again in external mode, cleared when crystal request drops
        i_crystal_request <= 1'b1;
        i_ext_ref_out_enable <= 1'b1;
        i_osc_startup_done <= 1'b1;
        cyc(5);
        rd_chk(CGTS_STAT_OFS, 8'h02, 8'h02);
        i_ext_ref_out_enable <= 1'b0;
        cyc(4);
        rd_chk(CGTS_STAT_OFS, 8'h00, 8'h02);
        i_system_source_select <= CGTS_SRC_EXT;
        cyc(5);
        rd_chk(CGTS_STAT_OFS, 8'h02, 8'h02);
        i_crystal_request <= 1'b0;
        i_system_source_select <= CGTS_SRC_LOOP;
        cyc(4);
        rd_chk(CGTS_STAT_OFS, 8'h00, 8'h02);
        `CHK(o_ext_clock_select, 1'b1)
        // lock tracking in the internal engaged mode
        `CHK(o_fll_enable, 1'b1)
        `CHK(o_lock_detect_en, 1'b1)
        i_raw_lock <= 1'b1;
        cyc(4);
        rd_chk(CGTS_STAT_OFS, 8'h40, 8'hC0);
        i_vco_multiplier <= 4'h5;
        cyc(3);
        rd_chk(CGTS_STAT_OFS, 8'h40, 8'h40);
        wr(CGTS_TRIM_OFS, 8'h33);
        cyc(2);
        rd_chk(CGTS_STAT_OFS, 8'h00, 8'h40);
        i_raw_lock <= 1'b0;
        cyc(4);
        i_raw_lock <= 1'b1;
        cyc(4);
        rd_chk(CGTS_STAT_OFS, 8'h40, 8'h40);
        i_out_of_tolerance <= 1'b1;
        cyc(4);
        i_out_of_tolerance <= 1'b0;
        cyc(4);
        rd_chk(CGTS_STAT_OFS, 8'h80, 8'h80);
        `CHK(o_irq, 1'b0)
        wr(CGTS_STAT_OFS, 8'h00);
        rd_chk(CGTS_STAT_OFS, 8'h80, 8'h80);
        wr(CGTS_CTRL_OFS, 8'h80);
        cyc(2);
        `CHK(o_irq, 1'b1)
        rd_chk(CGTS_CTRL_OFS, 8'h80, 8'hFF);
        wr(CGTS_STAT_OFS, 8'h80);
        cyc(2);
        rd_chk(CGTS_STAT_OFS, 8'h00, 8'h80);
        `CHK(o_irq, 1'b0)
        // low-power bypass and stop drop the lock until relock
        i_system_source_select <= CGTS_SRC_INT;
        i_low_power_select <= 1'b1;
        cyc(4);
        `CHK(o_lock_detect_en, 1'b0)
        rd_chk(CGTS_STAT_OFS, 8'h00, 8'h40);
        i_low_power_select <= 1'b0;
        cyc(4);
        rd_chk(CGTS_STAT_OFS, 8'h00, 8'h40);
        i_stop_mode <= 1'b1;
        cyc(4);
        i_stop_mode <= 1'b0;
        cyc(4);
        rd_chk(CGTS_STAT_OFS, 8'h00, 8'h40);
        // phase-locked engaged external mode
        i_system_source_select <= CGTS_SRC_LOOP;
        i_ref_source_select <= 1'b0;
        i_loop_type_select <= 1'b1;
        i_crystal_request <= 1'b1;
        cyc(4);
        `CHK(o_pll_enable, 1'b1)
        `CHK(o_fll_enable, 1'b0)
        `CHK(o_crystal_select, 1'b1)
        final_report();
    end
endmodule
